/* File: rtl/pwm_timer_pkg.sv */
// Shared constants for the eight-bit PWM timer block.
package pwm_timer_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   // Counter extremes.
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   // Waveform mode field encodings.
   localparam logic [1:0] MODE_PHASE = 2'h1;
   localparam logic [1:0] MODE_FAST = 2'h3;
   // Compare output mode field encodings.
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_COMPARE = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_PORT = 8'h10;
   // Field positions.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_COM_LSB = 2;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMF_BIT = 1;
   localparam int PORT_VAL_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int PORT_PIN_BIT = 2;
   localparam int PORT_OC_BIT = 3;
   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
endpackage : pwm_timer_pkg

/* File: rtl/compare_buffer.sv */
// Double-buffered compare value holder.
`timescale 1ns/1ns
module compare_buffer #(
   parameter int W = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic load_i,
   input wire logic bypass_i,
   output logic [W-1:0] buf_o,
   output logic [W-1:0] act_o
);
   typedef struct packed {
      logic [W-1:0] buf_v;
      logic [W-1:0] act;
   } buf_state_t;

   buf_state_t s_r;
   buf_state_t s_nxt;

   // Unless bypass_i is set, the comparator only sees a new value at the update
   // point, so a write mid-period cannot cut a pulse short.
   always_comb begin
      s_nxt = s_r;
      if (wr_i) begin
         s_nxt.buf_v = wdata_i;
      end
      if (bypass_i && wr_i) begin
         s_nxt.act = wdata_i;
      end else if (load_i) begin
         s_nxt.act = s_r.buf_v;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign buf_o = s_r.buf_v;
   assign act_o = s_r.act;
endmodule : compare_buffer

/* File: rtl/pin_mux.sv */
// Port pin driver that lets the compare output take over the pin.
`timescale 1ns/1ns
module pin_mux (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic override_i,
   input wire logic oc_i,
   input wire logic port_val_i,
   input wire logic dir_i,
   output logic pin_o,
   output logic pin_oe_o
);
   typedef struct packed {
      logic pin;
      logic oe;
   } pin_state_t;

   pin_state_t s_r;
   pin_state_t s_nxt;

   always_comb begin
      s_nxt.pin = override_i ? oc_i : port_val_i;
      s_nxt.oe = dir_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign pin_o = s_r.pin;
   assign pin_oe_o = s_r.oe;
endmodule : pin_mux

/* File: rtl/pwm_timer.sv */
// Eight-bit timer with fast and phase correct PWM generation.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
module pwm_timer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic timer_tick_enable_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic compare_output_o,
   output logic overflow_flag_o,
   output logic compare_match_flag_o
);
   typedef struct packed {
      logic [1:0] waveform_mode_field;
      logic [1:0] compare_output_mode_field;
      logic [7:0] counter_value;
      logic dir_down;
      logic block;
      logic overflow_flag;
      logic compare_match_flag;
      logic compare_output;
      logic port_val;
      logic pin_direction_bit;
      logic [7:0] rdata;
   } timer_state_t;

   timer_state_t s_r;
   timer_state_t s_nxt;

   logic fast;
   logic phase;
   logic adv;
   logic match;
   logic up_match;
   logic at_max;
   logic at_bottom;
   logic ctrl_wr;
   logic cnt_wr;
   logic cmp_wr;
   logic flag_wr;
   logic port_wr;
   logic cmp_load;
   logic [7:0] compare_value;
   logic [7:0] compare_value_alias;

   assign fast = (s_r.waveform_mode_field == pwm_timer_pkg::MODE_FAST);
   assign phase = (s_r.waveform_mode_field == pwm_timer_pkg::MODE_PHASE);
   // The tick is only ever an enable on the system clock, never a clock. Other
   // modes leave the counter still.
   assign adv = ce_i && timer_tick_enable_i && (fast || phase);
   assign at_max = (s_r.counter_value == pwm_timer_pkg::CNT_MAX);
   assign at_bottom = (s_r.counter_value == pwm_timer_pkg::CNT_BOTTOM);
   assign match = adv && !s_r.block && (s_r.counter_value == compare_value_alias);
   // Bottom starts an up slope; max itself counts as the down side.
   assign up_match = at_bottom || (!s_r.dir_down && !at_max);

   assign ctrl_wr = wr_i && (addr_i == pwm_timer_pkg::OFS_CTRL);
   assign cnt_wr = wr_i && (addr_i == pwm_timer_pkg::OFS_COUNT);
   assign cmp_wr = wr_i && (addr_i == pwm_timer_pkg::OFS_COMPARE);
   assign flag_wr = wr_i && (addr_i == pwm_timer_pkg::OFS_FLAGS);
   assign port_wr = wr_i && (addr_i == pwm_timer_pkg::OFS_PORT);
   // Both PWM modes reload the comparator where the counter turns at max.
   assign cmp_load = adv && at_max;

   compare_buffer #(
      .W(pwm_timer_pkg::DATA_W)
   ) u_cmp (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(cmp_wr),
      .wdata_i(wdata_i),
      .load_i(cmp_load),
      .bypass_i(!(fast || phase)),
      .buf_o(compare_value),
      .act_o(compare_value_alias)
   );

   pin_mux u_pin (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .override_i(s_r.compare_output_mode_field != pwm_timer_pkg::COM_OFF),
      .oc_i(s_r.compare_output),
      .port_val_i(s_r.port_val),
      .dir_i(s_r.pin_direction_bit),
      .pin_o(pin_o),
      .pin_oe_o(pin_oe_o)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
      if (fast && adv) begin
         s_nxt.counter_value = at_max ? pwm_timer_pkg::CNT_BOTTOM : s_r.counter_value + 8'h01;
         if (match) begin
            case (s_r.compare_output_mode_field)
               pwm_timer_pkg::COM_TOGGLE: s_nxt.compare_output = !s_r.compare_output;
               pwm_timer_pkg::COM_CLEAR: s_nxt.compare_output = 1'b0;
               pwm_timer_pkg::COM_SET: s_nxt.compare_output = 1'b1;
               default: s_nxt.compare_output = s_r.compare_output;
            endcase
         end
         // The wrap action wins over a match at max, so a compare of max
         // gives a steady level and a compare of bottom a one-tick spike.
         if (at_max) begin
            if (s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR) begin
               s_nxt.compare_output = 1'b1;
            end else if (s_r.compare_output_mode_field == pwm_timer_pkg::COM_SET) begin
               s_nxt.compare_output = 1'b0;
            end
         end
      end else if (phase && adv) begin
         if (at_max) begin
            s_nxt.counter_value = pwm_timer_pkg::CNT_MAX - 8'h01;
            s_nxt.dir_down = 1'b1;
         end else if (at_bottom) begin
            s_nxt.counter_value = pwm_timer_pkg::CNT_BOTTOM + 8'h01;
            s_nxt.dir_down = 1'b0;
         end else if (s_r.dir_down) begin
            s_nxt.counter_value = s_r.counter_value - 8'h01;
         end else begin
            s_nxt.counter_value = s_r.counter_value + 8'h01;
         end
         if (match) begin
            case (s_r.compare_output_mode_field)
               pwm_timer_pkg::COM_CLEAR: s_nxt.compare_output = !up_match;
               pwm_timer_pkg::COM_SET: s_nxt.compare_output = up_match;
               default: s_nxt.compare_output = s_r.compare_output;
            endcase
         end
         // Without this, a compare that left max or a start above the compare
         // value would lose symmetry around bottom.
         if (at_max && (compare_value_alias != pwm_timer_pkg::CNT_MAX)) begin
            if (s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR) begin
               s_nxt.compare_output = 1'b0;
            end else if (s_r.compare_output_mode_field == pwm_timer_pkg::COM_SET) begin
               s_nxt.compare_output = 1'b1;
            end
         end
      end
      // A tick ends the blocking window, whether or not the counter runs.
      if (ce_i && timer_tick_enable_i) begin
         s_nxt.block = 1'b0;
      end
      if (ctrl_wr) begin
         s_nxt.waveform_mode_field = wdata_i[pwm_timer_pkg::CTRL_MODE_LSB +: 2];
         s_nxt.compare_output_mode_field = wdata_i[pwm_timer_pkg::CTRL_COM_LSB +: 2];
      end
      if (cnt_wr) begin
         s_nxt.counter_value = wdata_i;
         s_nxt.block = 1'b1;
      end
      if (port_wr) begin
         s_nxt.port_val = wdata_i[pwm_timer_pkg::PORT_VAL_BIT];
         s_nxt.pin_direction_bit = wdata_i[pwm_timer_pkg::PORT_DIR_BIT];
      end
      // Flags clear on a one written; a set in the same cycle wins.
      s_nxt.overflow_flag = (s_r.overflow_flag && !(flag_wr && wdata_i[pwm_timer_pkg::FLAG_OVF_BIT]))
         || (adv && fast && at_max)
         || (adv && phase && at_bottom);
      s_nxt.compare_match_flag = (s_r.compare_match_flag && !(flag_wr && wdata_i[pwm_timer_pkg::FLAG_CMF_BIT]))
         || match;
      if (rd_i) begin
         if (addr_i == pwm_timer_pkg::OFS_CTRL) begin
            s_nxt.rdata = {4'h0, s_r.compare_output_mode_field, s_r.waveform_mode_field};
         end else if (addr_i == pwm_timer_pkg::OFS_COUNT) begin
            s_nxt.rdata = s_r.counter_value;
         end else if (addr_i == pwm_timer_pkg::OFS_COMPARE) begin
            s_nxt.rdata = compare_value;
         end else if (addr_i == pwm_timer_pkg::OFS_FLAGS) begin
            s_nxt.rdata = {6'h00, s_r.compare_match_flag, s_r.overflow_flag};
         end else if (addr_i == pwm_timer_pkg::OFS_PORT) begin
            s_nxt.rdata = {4'h0, s_r.compare_output, pin_i, s_r.pin_direction_bit, s_r.port_val};
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.waveform_mode_field <= pwm_timer_pkg::CTRL_RESET[1:0];
         s_r.counter_value <= pwm_timer_pkg::COUNT_RESET;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata;
   assign compare_output_o = s_r.compare_output;
   assign overflow_flag_o = s_r.overflow_flag;
   assign compare_match_flag_o = s_r.compare_match_flag;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_FAST_INC: assert property (fast && adv && !at_max && !cnt_wr && !ctrl_wr
      |=> s_r.counter_value == $past(s_r.counter_value) + 8'h01)
      else $error("Fast PWM counter did not increment.");

   AST_FAST_WRAP: assert property (fast && adv && at_max && !cnt_wr |=> at_bottom)
      else $error("Fast PWM counter did not wrap to bottom after max.");

   AST_FAST_SET_AT_WRAP: assert property (fast && adv && at_max && !ctrl_wr
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR |=> s_r.compare_output)
      else $error("Non-inverted fast PWM output not set at wrap.");

   AST_FAST_CLR_AT_WRAP: assert property (fast && adv && at_max && !ctrl_wr
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_SET |=> !s_r.compare_output)
      else $error("Inverted fast PWM output not cleared at wrap.");

   AST_FAST_OVF: assert property (fast && adv && at_max |=> s_r.overflow_flag)
      else $error("Overflow flag not set at max in fast PWM.");

   AST_PC_HOLD: assert property (phase && adv && at_max && !cnt_wr && !ctrl_wr
      |=> s_r.dir_down && s_r.counter_value == 8'hfe)
      else $error("Phase correct counter did not turn after one tick at max.");

   AST_PC_OVF: assert property (phase && adv && at_bottom |=> s_r.overflow_flag)
      else $error("Overflow flag not set at bottom in phase correct PWM.");

   AST_PC_FORCE: assert property (phase && adv && at_max && !ctrl_wr
      && compare_value_alias != pwm_timer_pkg::CNT_MAX
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR |=> !s_r.compare_output)
      else $error("Output not forced to up-match state at max.");

   // The window opens the cycle after the write, so the check keys on the block bit while a tick arrives.
   AST_BLOCK: assert property (adv && s_r.block |=> !$rose(s_r.compare_match_flag))
      else $error("Match not blocked after a counter write.");

   AST_MATCH_FLAG: assert property (match |=> s_r.compare_match_flag)
      else $error("Compare match flag not set on a match.");

   AST_PIN: assert property (ce_i && s_r.compare_output_mode_field != pwm_timer_pkg::COM_OFF
      |=> pin_o == $past(s_r.compare_output) && pin_oe_o == $past(s_r.pin_direction_bit))
      else $error("Compare output did not take over the pin.");

   AST_FAST_MATCH_CLR: assert property (fast && match && !at_max
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR |=> !s_r.compare_output)
      else $error("Non-inverted fast PWM output not cleared on a match.");

   AST_FAST_MATCH_SET: assert property (fast && match && !at_max
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_SET |=> s_r.compare_output)
      else $error("Inverted fast PWM output not set on a match.");

   AST_FAST_TOGGLE: assert property (fast && match
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_TOGGLE |=> s_r.compare_output != $past(s_r.compare_output))
      else $error("Fast PWM output did not toggle on a match.");

   AST_NO_ACTION: assert property (match && s_r.compare_output_mode_field == pwm_timer_pkg::COM_OFF
      |=> $stable(s_r.compare_output))
      else $error("Compare output changed with the action disabled.");

   // Matches on the rising slope clear a non-inverted output and those on the falling slope set it.
   AST_PC_UP_MATCH: assert property (phase && match && !s_r.dir_down && !at_max
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR |=> !s_r.compare_output)
      else $error("Phase correct output not cleared on an up-count match.");

   AST_PC_DOWN_MATCH: assert property (phase && match && s_r.dir_down && !at_bottom
      && s_r.compare_output_mode_field == pwm_timer_pkg::COM_CLEAR |=> s_r.compare_output)
      else $error("Phase correct output not set on a down-count match.");

   AST_PC_STEP_UP: assert property (phase && adv && !s_r.dir_down && !at_max && !at_bottom
      && !cnt_wr && !ctrl_wr |=> s_r.counter_value == $past(s_r.counter_value) + 8'h01)
      else $error("Phase correct counter did not count up.");

   AST_PC_STEP_DOWN: assert property (phase && adv && s_r.dir_down && !at_max && !at_bottom
      && !cnt_wr && !ctrl_wr |=> s_r.counter_value == $past(s_r.counter_value) - 8'h01)
      else $error("Phase correct counter did not count down.");

   AST_PC_TURN_UP: assert property (phase && adv && at_bottom && !cnt_wr && !ctrl_wr
      |=> !s_r.dir_down && s_r.counter_value == 8'h01)
      else $error("Phase correct counter did not turn at bottom.");

   // Without a tick or a counter write the counter must hold, whatever the mode.
   AST_STOPPED: assert property (!adv && !cnt_wr |=> $stable(s_r.counter_value))
      else $error("Counter moved without a tick.");

   AST_FREEZE: assert property (!ce_i |=> $stable(s_r))
      else $error("State moved while the clock enable was low.");

   AST_CMF_CAUSE: assert property ($rose(s_r.compare_match_flag) |-> $past(match))
      else $error("Compare match flag set without a match.");

   AST_OVF_CAUSE: assert property ($rose(s_r.overflow_flag)
      |-> $past(adv && ((fast && at_max) || (phase && at_bottom))))
      else $error("Overflow flag set outside its overflow point.");

   AST_PIN_PORT: assert property (ce_i && s_r.compare_output_mode_field == pwm_timer_pkg::COM_OFF
      |=> pin_o == $past(s_r.port_val))
      else $error("Port value did not reach the pin.");

   // Cover points for the main scenarios.
   COV_FAST_WRAP: cover property (fast && adv && at_max ##1 at_bottom);
   COV_PC_FORCE: cover property (phase && adv && at_max && compare_value_alias != pwm_timer_pkg::CNT_MAX);
   COV_BLOCKED: cover property (adv && s_r.block && s_r.counter_value == compare_value_alias);
   COV_PC_TURN: cover property (phase && adv && at_max ##1 s_r.dir_down);
   COV_MATCH: cover property (match ##1 s_r.compare_match_flag);
endmodule : pwm_timer

/* File: tb/pin_load_model.sv */
// External load on the compare pin that counts high samples and level changes.
`timescale 1ns/1ns
module pin_load_model (
   input wire logic sys_clk_i,
   input wire logic clr_i,
   input wire logic drive_i,
   input wire logic oe_i,
   output logic level_o,
   output logic [15:0] high_cnt_o,
   output logic [15:0] edge_cnt_o
);
   logic prev_r;
   // A released pin goes to the pull-up level, so a stale driven value can never pass for a match.
   assign level_o = oe_i ? drive_i : 1'b1;
   always_ff @(posedge sys_clk_i) begin
      if (clr_i) begin
         high_cnt_o <= 16'h0000;
         edge_cnt_o <= 16'h0000;
      end else begin
         high_cnt_o <= high_cnt_o + {15'h0000, level_o};
         edge_cnt_o <= edge_cnt_o + {15'h0000, level_o != prev_r};
      end
      prev_r <= level_o;
   end
endmodule : pin_load_model

/* File: tb/testbench.sv */
// Self-checking bench for the eight-bit PWM timer.
`timescale 1ns/1ns
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic tick = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic clr = 1'b0;
   logic ce = 1'b1;
   logic [7:0] rdata;
   logic [7:0] rv;
   logic pin_lvl, pin, pin_oe, oc, ovf, cmf;
   logic [15:0] hi_cnt, edge_cnt;
   int errors = 0;
   int n_compared = 0;
   int k;
   int p;
   logic [7:0] r_ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
   // Each row: control byte, compare value, port value, high samples and level changes per period.
   logic [7:0] t_ctrl [11] = '{8'h0b, 8'h0f, 8'h0b, 8'h0b, 8'h0f, 8'h07, 8'h03, 8'h09, 8'h0d, 8'h09, 8'h0d};
   logic [7:0] t_cmp [11] = '{8'h40, 8'h40, 8'h00, 8'hff, 8'hff, 8'h00, 8'h40, 8'h40, 8'h40, 8'h00, 8'hff};
   logic t_val [11] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   // The toggle row has no fixed high count over one window, so ffff means not compared.
   logic [15:0] t_hi [11] = '{16'h0041, 16'h00bf, 16'h0001, 16'h0100, 16'h0000, 16'hffff, 16'h0100,
      16'h0080, 16'h017e, 16'h0000, 16'h0000};
   logic [15:0] t_ed [11] = '{16'h2, 16'h2, 16'h2, 16'h0, 16'h0, 16'h1, 16'h0, 16'h2, 16'h2, 16'h0, 16'h0};

   always #5 sys_clk_i = ~sys_clk_i;

   pwm_timer pwm_timer_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .timer_tick_enable_i(tick),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_i(pin_lvl), .pin_o(pin),
      .pin_oe_o(pin_oe), .compare_output_o(oc), .overflow_flag_o(ovf), .compare_match_flag_o(cmf));
   pin_load_model pin_load_model_inst (.sys_clk_i(sys_clk_i), .clr_i(clr), .drive_i(pin), .oe_i(pin_oe),
      .level_o(pin_lvl), .high_cnt_o(hi_cnt), .edge_cnt_o(edge_cnt));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic pulse;
      @(posedge sys_clk_i);
      tick <= 1'b1;
      @(posedge sys_clk_i);
      tick <= 1'b0;
   endtask : pulse

   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd_reg(r_ofs[i], rv);
         check("reset value", {8'h00, rv}, 16'h0000);
      end
      // Counter stepping under explicit ticks.
      wr_reg(pwm_timer_pkg::OFS_COMPARE, 8'h10);
      wr_reg(pwm_timer_pkg::OFS_COUNT, 8'h10);
      wr_reg(pwm_timer_pkg::OFS_CTRL, 8'h03);
      repeat (5) @(posedge sys_clk_i);
      rd_reg(pwm_timer_pkg::OFS_COUNT, rv);
      check("count idle", {8'h00, rv}, 16'h0010);
      // A tick with the clock enable low must leave the counter and the blocking window alone.
      ce <= 1'b0;
      pulse();
      ce <= 1'b1;
      rd_reg(pwm_timer_pkg::OFS_COUNT, rv);
      check("count frozen", {8'h00, rv}, 16'h0010);
      pulse();
      rd_reg(pwm_timer_pkg::OFS_FLAGS, rv);
      check("blocked match", {8'h00, rv}, 16'h0000);
      rd_reg(pwm_timer_pkg::OFS_COUNT, rv);
      check("count step", {8'h00, rv}, 16'h0011);
      wr_reg(pwm_timer_pkg::OFS_COUNT, 8'hfe);
      pulse();
      pulse();
      rd_reg(pwm_timer_pkg::OFS_COUNT, rv);
      check("count wrap", {8'h00, rv}, 16'h0000);
      rd_reg(pwm_timer_pkg::OFS_FLAGS, rv);
      check("overflow at max", {8'h00, rv}, 16'h0001);
      tick <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         p = (t_ctrl[i][1:0] == pwm_timer_pkg::MODE_PHASE) ? 510 : 256;
         wr_reg(pwm_timer_pkg::OFS_CTRL, 8'h00);
         wr_reg(pwm_timer_pkg::OFS_FLAGS, 8'h03);
         wr_reg(pwm_timer_pkg::OFS_COMPARE, t_cmp[i]);
         wr_reg(pwm_timer_pkg::OFS_PORT, {6'h00, 1'b1, t_val[i]});
         wr_reg(pwm_timer_pkg::OFS_CTRL, t_ctrl[i]);
         check("pin enable", {15'h0000, pin_oe}, 16'h0001);
         k = 0;
         #1;
         while (ovf !== 1'b1 && k < 600) begin
            @(posedge sys_clk_i);
            #1 k++;
         end
         if (ovf !== 1'b1) begin
            errors++;
            $display("unexpected overflow wait: expected 1, seen %b", ovf);
            test_done();
         end
         // Two periods let the compare output reach its steady waveform before measuring.
         repeat (2 * p) @(posedge sys_clk_i);
         clr <= 1'b1;
         @(posedge sys_clk_i);
         clr <= 1'b0;
         repeat (p) @(posedge sys_clk_i);
         #1;
         if (t_hi[i] !== 16'hffff) begin
            check("high samples", hi_cnt, t_hi[i]);
         end
         check("level changes", edge_cnt, t_ed[i]);
         if (t_ed[i] == 16'h0000 && t_ctrl[i][3:2] != 2'h0) begin
            check("compare output", {15'h0000, oc}, {15'h0000, t_hi[i] != 16'h0000});
         end
         wr_reg(pwm_timer_pkg::OFS_CTRL, 8'h00);
         rd_reg(pwm_timer_pkg::OFS_FLAGS, rv);
         check("overflow flag", {15'h0000, rv[0]}, 16'h0001);
         check("match flag", {15'h0000, rv[1]}, 16'h0001);
      end
      test_done();
   end
endmodule : testbench
